// ===== inc/run_stats_pkg.sv
// Package: register map, field layout, timing and encodings of the run statistics block
package run_stats_pkg;

	// ----------------------------------------------------------------
	// Register indices (word addresses on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_RUN_HOURS_BASIC = 4'h0;
	localparam logic [3:0] ADDR_RUN_HOURS_THOUSANDS = 4'h1;
	localparam logic [3:0] ADDR_RUN_CYCLES_BASIC = 4'h2;
	localparam logic [3:0] ADDR_RUN_CYCLES_TEN_THOUSANDS = 4'h3;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_FULL_LOAD_CURRENT = 4'h5;
	localparam logic [3:0] ADDR_STOP_LEVEL = 4'h6;
	localparam logic [3:0] ADDR_LOW_CURRENT = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_TRIP_CODE = 4'h9;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_SOFT_STOP_BIT = 0;
	localparam int CTRL_PHASE_LOSS_EN_BIT = 1;
	localparam int CTRL_TRIP_CLEAR_BIT = 2;
	localparam logic [15:0] CTRL_RESET = 16'h0002;

	// ----------------------------------------------------------------
	// Reset values and counter limits
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] FLC_RESET = 16'h0000;
	localparam logic [15:0] STOP_LEVEL_RESET = 16'h0000;
	localparam logic [15:0] LOW_CURRENT_RESET = 16'h0000;
	localparam logic [15:0] HOURS_TENTHS_MAX = 16'd9999;
	localparam logic [15:0] COUNT_MAX = 16'd9999;

	// ----------------------------------------------------------------
	// Timing: clock rate, six-minute tenth-hour tick, phase-loss wait
	// ----------------------------------------------------------------
	localparam longint CLK_HZ = 10000000;
	localparam longint TENTH_HOUR_S = 360;
	localparam longint TENTH_HOUR_CYCLES = TENTH_HOUR_S * CLK_HZ;
	localparam longint PHASE_LOSS_S = 3;
	localparam longint PHASE_LOSS_CYCLES = PHASE_LOSS_S * CLK_HZ;

	// ----------------------------------------------------------------
	// Trip code characters (ASCII) and trip conditions
	// ----------------------------------------------------------------
	localparam logic [7:0] CHAR_ACCEL = 8'h41;
	localparam logic [7:0] CHAR_CONST = 8'h63;
	localparam logic [7:0] CHAR_DECEL = 8'h64;
	localparam logic [15:0] COND_PHASE_LOSS = 16'h504C;
	localparam logic [15:0] COND_EXTERNAL_NONE = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACCEL,
		ST_RUN,
		ST_DECEL,
		ST_TRIP
	} motor_state_t;

endpackage

// ===== inc/stat_if.sv
// Interface: tick and count-event signals between sequencer and statistics counters
interface stat_if;
	logic tenth_hour;
	logic run_cycle;
	logic [15:0] hours_basic;
	logic [15:0] hours_thousands;
	logic [15:0] cycles_basic;
	logic [15:0] cycles_ten_thousands;

	modport src (output tenth_hour, output run_cycle,
		input hours_basic, input hours_thousands,
		input cycles_basic, input cycles_ten_thousands);
	modport cnt (input tenth_hour, input run_cycle,
		output hours_basic, output hours_thousands,
		output cycles_basic, output cycles_ten_thousands);
endinterface

// ===== rtl/run_statistics_and_fault_tag.sv
// Module: motor start sequencer, run statistics and phase-tagged trip codes
module run_statistics_and_fault_tag
	import run_stats_pkg::*;
#(
	parameter longint TENTH_HOUR_CNT = TENTH_HOUR_CYCLES,
	parameter longint PHASE_LOSS_CNT = PHASE_LOSS_CYCLES
)(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	input wire logic RUN_CMD_I,
	input wire logic JOG_I,
	input wire logic LINE_OK_I,
	input wire logic FULL_SPEED_I,
	input wire logic [15:0] CURRENT_I,
	input wire logic EXT_TRIP_I,
	input wire logic [15:0] EXT_COND_I,
	output logic MOTOR_ON_O,
	output logic AT_SPEED_O,
	output logic TRIP_O,
	output logic [23:0] TRIP_CODE_O
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	motor_state_t state_q, state_d;
	logic [15:0] ctrl_q;
	logic [15:0] flc_q;
	logic [15:0] stop_lvl_q;
	logic [15:0] low_cur_q;
	logic [31:0] hour_div_q;
	logic [31:0] pl_cnt_q;
	logic [23:0] code_q;
	logic tick_q;
	logic cycle_q;
	logic motor_on_q;
	logic at_speed_q;
	logic trip_q;
	logic [15:0] rdata_q;

	stat_if st ();

	stat_counters u_cnt (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.st(st.cnt)
	);

	// ----------------------------------------------------------------
	// Decode and condition wires
	// ----------------------------------------------------------------
	wire wr_ctrl = WR_I && (ADDR_I == ADDR_CONTROL);
	wire wr_flc = WR_I && (ADDR_I == ADDR_FULL_LOAD_CURRENT);
	wire wr_stop = WR_I && (ADDR_I == ADDR_STOP_LEVEL);
	wire wr_low = WR_I && (ADDR_I == ADDR_LOW_CURRENT);
	wire trip_clr = wr_ctrl && WDATA_I[CTRL_TRIP_CLEAR_BIT];
	wire soft_stop = ctrl_q[CTRL_SOFT_STOP_BIT];
	wire pl_en = ctrl_q[CTRL_PHASE_LOSS_EN_BIT];
	wire flc_ok = (flc_q != FLC_RESET);
	wire start_ok = RUN_CMD_I && LINE_OK_I && flc_ok;
	wire jog_ok = JOG_I && LINE_OK_I && flc_ok;
	wire running = (state_q == ST_ACCEL) || (state_q == ST_RUN) ||
		(state_q == ST_DECEL);
	// Time accrues in every powered phase, jog included
	wire timing = running || (state_q == ST_IDLE && jog_ok);
	wire low_cur = CURRENT_I < low_cur_q;
	// Fires only if the last cycle of the window is still low
	wire pl_fire = pl_en && (state_q == ST_RUN) && low_cur &&
		(pl_cnt_q == 32'(PHASE_LOSS_CNT - 1));
	// A trip still present at the clear wins over the clear
	wire trip_evt = (EXT_TRIP_I || pl_fire) &&
		((state_q != ST_TRIP) || trip_clr);
	wire [15:0] cond = pl_fire ? COND_PHASE_LOSS : EXT_COND_I;
	wire div_end = (hour_div_q == 32'(TENTH_HOUR_CNT - 1));
	wire reach_speed = (state_q == ST_ACCEL) && FULL_SPEED_I && RUN_CMD_I;

	// Phase suffix from the state in force at the trip
	function automatic logic [7:0] suffix(input motor_state_t s);
		unique case (s)
			ST_ACCEL: suffix = CHAR_ACCEL;
			ST_RUN: suffix = CHAR_CONST;
			ST_IDLE, ST_DECEL, ST_TRIP: suffix = CHAR_DECEL;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_ok)
					state_d = ST_ACCEL;
			end
			ST_ACCEL: begin
				if (!RUN_CMD_I)
					state_d = soft_stop ? ST_DECEL : ST_IDLE;
				else if (FULL_SPEED_I)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!RUN_CMD_I)
					state_d = soft_stop ? ST_DECEL : ST_IDLE;
			end
			ST_DECEL: begin
				if (CURRENT_I <= stop_lvl_q)
					state_d = ST_IDLE;
			end
			ST_TRIP: begin
				if (trip_clr)
					state_d = ST_IDLE;
			end
		endcase
		// Trip overrides every other move
		if (trip_evt)
			state_d = ST_TRIP;
	end

	// ----------------------------------------------------------------
	// State and output flops
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q <= ST_IDLE;
			motor_on_q <= 1'b0;
			at_speed_q <= 1'b0;
			trip_q <= 1'b0;
		end else if (CE_I) begin
			state_q <= state_d;
			motor_on_q <= (state_d == ST_ACCEL) || (state_d == ST_RUN) ||
				(state_d == ST_DECEL) ||
				(state_d == ST_IDLE && jog_ok);
			at_speed_q <= (state_d == ST_RUN);
			trip_q <= (state_d == ST_TRIP);
		end
	end

	// ----------------------------------------------------------------
	// Trip code capture: condition pair plus phase character
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			code_q <= 24'h000000;
		else if (CE_I && trip_evt)
			code_q <= {cond, suffix(state_q)};
	end

	// ----------------------------------------------------------------
	// Phase-loss timer: counts continuous low-current cycles at speed
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			pl_cnt_q <= 32'h00000000;
		else if (CE_I) begin
			if (state_q == ST_RUN && low_cur && pl_en && !pl_fire)
				pl_cnt_q <= pl_cnt_q + 32'h00000001;
			else
				pl_cnt_q <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Six-minute divider; remainder kept across stops so time is exact
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hour_div_q <= 32'h00000000;
			tick_q <= 1'b0;
			cycle_q <= 1'b0;
		end else if (CE_I) begin
			tick_q <= timing && div_end;
			cycle_q <= reach_speed && !trip_evt;
			if (timing)
				hour_div_q <= div_end ? 32'h00000000 :
					hour_div_q + 32'h00000001;
		end
	end

	assign st.tenth_hour = tick_q && CE_I;
	assign st.run_cycle = cycle_q && CE_I;

	// ----------------------------------------------------------------
	// Software-written settings
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_q <= CTRL_RESET;
			flc_q <= FLC_RESET;
			stop_lvl_q <= STOP_LEVEL_RESET;
			low_cur_q <= LOW_CURRENT_RESET;
		end else if (CE_I) begin
			if (wr_ctrl)
				ctrl_q <= WDATA_I & ~(16'h0001 << CTRL_TRIP_CLEAR_BIT);
			if (wr_flc)
				flc_q <= WDATA_I;
			if (wr_stop)
				stop_lvl_q <= WDATA_I;
			if (wr_low)
				low_cur_q <= WDATA_I;
		end
	end

	// ----------------------------------------------------------------
	// Read path: data stands one cycle after the strobe, zero otherwise
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		unique case (ADDR_I)
			ADDR_RUN_HOURS_BASIC: rd_mux = st.hours_basic;
			ADDR_RUN_HOURS_THOUSANDS: rd_mux = st.hours_thousands;
			ADDR_RUN_CYCLES_BASIC: rd_mux = st.cycles_basic;
			ADDR_RUN_CYCLES_TEN_THOUSANDS: rd_mux = st.cycles_ten_thousands;
			ADDR_CONTROL: rd_mux = ctrl_q;
			ADDR_FULL_LOAD_CURRENT: rd_mux = flc_q;
			ADDR_STOP_LEVEL: rd_mux = stop_lvl_q;
			ADDR_LOW_CURRENT: rd_mux = low_cur_q;
			ADDR_STATUS: rd_mux = {11'h000, !flc_ok, trip_q, at_speed_q,
				motor_on_q, 1'b0};
			ADDR_TRIP_CODE: rd_mux = {8'h00, code_q[7:0]};
			default: rd_mux = 16'h0000; // Unmapped reads zero
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			rdata_q <= 16'h0000;
		else if (CE_I)
			rdata_q <= RD_I ? rd_mux : 16'h0000;
	end

	assign RDATA_O = rdata_q;
	assign MOTOR_ON_O = motor_on_q;
	assign AT_SPEED_O = at_speed_q;
	assign TRIP_O = trip_q;
	assign TRIP_CODE_O = code_q;

endmodule

// ===== rtl/stat_counters.sv
// Module: run-time meter and run-cycle counter with overflow counters
module stat_counters
	import run_stats_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	stat_if.cnt st
);

	logic [15:0] hb_q;
	logic [15:0] hk_q;
	logic [15:0] cb_q;
	logic [15:0] ck_q;

	// Decimal wrap helper: step a 0..9999 counter
	function automatic logic [15:0] step(input logic [15:0] v,
		input logic [15:0] lim);
		step = (v == lim) ? COUNTER_RESET : v + 16'h0001;
	endfunction

	wire hb_wrap = st.tenth_hour && (hb_q == HOURS_TENTHS_MAX);
	wire cb_wrap = st.run_cycle && (cb_q == COUNT_MAX);

	// Counters start from zero at reset; overflow counters wrap 9999 to 0
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hb_q <= COUNTER_RESET;
			hk_q <= COUNTER_RESET;
			cb_q <= COUNTER_RESET;
			ck_q <= COUNTER_RESET;
		end else if (ce_i) begin
			if (st.tenth_hour)
				hb_q <= step(hb_q, HOURS_TENTHS_MAX);
			if (hb_wrap)
				hk_q <= step(hk_q, COUNT_MAX);
			if (st.run_cycle)
				cb_q <= step(cb_q, COUNT_MAX);
			if (cb_wrap)
				ck_q <= step(ck_q, COUNT_MAX);
		end
	end

	assign st.hours_basic = hb_q;
	assign st.hours_thousands = hk_q;
	assign st.cycles_basic = cb_q;
	assign st.cycles_ten_thousands = ck_q;

endmodule

// ===== tb/motor_stage_model.sv
// Partner model: motor and power stage as seen from the starter pins
module motor_stage_model #(
	parameter int SPIN_UP = 6
)(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic motor_on_i,
	input wire logic [15:0] load_i,
	output logic full_speed_o,
	output logic [15:0] current_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] spin_q;
	// ----
	// Shaft
	// ----
	// Speed is lost at once when unpowered, so each start ramps in full
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			spin_q <= 8'h00;
		else if (!motor_on_i)
			spin_q <= 8'h00;
		else if (spin_q != 8'(SPIN_UP))
			spin_q <= spin_q + 8'h01;
	end
	// Inrush while ramping, load current at speed, none when off
	assign full_speed_o = motor_on_i && spin_q == 8'(SPIN_UP);
	assign current_o = !motor_on_i ? 16'h0000 :
		full_speed_o ? load_i : 16'h0300;
endmodule

// ===== tb/run_stats_chk.sv
// Checker: port-level assertions for the run statistics block
module run_stats_chk
	import run_stats_pkg::*;
#(
	parameter longint TENTH_HOUR_CNT = 20,
	parameter longint PHASE_LOSS_CNT = 10
)(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic RUN_CMD_I,
	input wire logic JOG_I,
	input wire logic LINE_OK_I,
	input wire logic FULL_SPEED_I,
	input wire logic [15:0] CURRENT_I,
	input wire logic EXT_TRIP_I,
	input wire logic [15:0] EXT_COND_I,
	input wire logic MOTOR_ON_O,
	input wire logic AT_SPEED_O,
	input wire logic TRIP_O,
	input wire logic [23:0] TRIP_CODE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	logic flc_set_q;
	logic ramp_q;
	logic [15:0] stop_q;
	wire logic wr_c = WR_I && CE_I;
	// Suffix owed now; ramp_q tells a ramp-up from a soft stop
	wire logic [7:0] phase_c = AT_SPEED_O ? CHAR_CONST :
		(MOTOR_ON_O && ramp_q) ? CHAR_ACCEL : CHAR_DECEL;
	// ----
	// Shadow state
	// ----
	// Settings are mirrored from writes, as the checker cannot read them
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			flc_set_q <= 1'b0;
			stop_q <= STOP_LEVEL_RESET;
			ramp_q <= 1'b1;
		end else begin
			if (wr_c && ADDR_I == ADDR_FULL_LOAD_CURRENT)
				flc_set_q <= WDATA_I != 16'h0000;
			if (wr_c && ADDR_I == ADDR_STOP_LEVEL)
				stop_q <= WDATA_I;
			ramp_q <= !MOTOR_ON_O || (ramp_q && !AT_SPEED_O);
		end
	end
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// Last ramp cycle and last soft-stop cycle
	sequence s_ramp_done;
		MOTOR_ON_O && ramp_q && !AT_SPEED_O && FULL_SPEED_I && RUN_CMD_I
			&& !EXT_TRIP_I;
	endsequence
	sequence s_decel_done;
		MOTOR_ON_O && !ramp_q && !AT_SPEED_O && !RUN_CMD_I
			&& CURRENT_I <= stop_q;
	endsequence
	property p_flc_gate;
		$rose(MOTOR_ON_O) |-> $past(flc_set_q);
	endproperty
	a_flc_gate: assert property (p_flc_gate)
		else $error("motor powered with zero full-load current");
	property p_start_cmd;
		$rose(MOTOR_ON_O) |-> $past(LINE_OK_I && (RUN_CMD_I || JOG_I));
	endproperty
	a_start_cmd: assert property (p_start_cmd)
		else $error("motor powered without line and command");
	property p_at_speed;
		s_ramp_done |=> AT_SPEED_O;
	endproperty
	a_at_speed: assert property (p_at_speed)
		else $error("at-speed not shown after full speed");
	property p_speed_off;
		AT_SPEED_O && !RUN_CMD_I |=> !AT_SPEED_O;
	endproperty
	a_speed_off: assert property (p_speed_off)
		else $error("at-speed kept after run removed");
	property p_soft_end;
		s_decel_done |=> !MOTOR_ON_O;
	endproperty
	a_soft_end: assert property (p_soft_end)
		else $error("soft stop kept power below stop level");
	property p_suffix;
		$rose(TRIP_O) |-> TRIP_CODE_O[7:0] == $past(phase_c);
	endproperty
	a_suffix: assert property (p_suffix)
		else $error("trip suffix does not match phase");
	property p_ext_cond;
		$rose(TRIP_O) && $past(EXT_TRIP_I)
			|-> TRIP_CODE_O[23:8] == $past(EXT_COND_I);
	endproperty
	a_ext_cond: assert property (p_ext_cond)
		else $error("trip condition characters wrong");
	property p_phase_loss;
		$rose(TRIP_O) && !$past(EXT_TRIP_I)
			|-> $past(AT_SPEED_O) && TRIP_CODE_O[23:8] == COND_PHASE_LOSS;
	endproperty
	a_phase_loss: assert property (p_phase_loss)
		else $error("internal trip not a running phase loss");
	property p_count_range;
		RD_I && ADDR_I < ADDR_CONTROL |=> RDATA_O <= COUNT_MAX;
	endproperty
	a_count_range: assert property (p_count_range)
		else $error("statistic counter out of range");
	property p_rd_idle;
		!RD_I && CE_I |=> RDATA_O == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
endmodule

bind run_statistics_and_fault_tag run_stats_chk #(
	.TENTH_HOUR_CNT(TENTH_HOUR_CNT),
	.PHASE_LOSS_CNT(PHASE_LOSS_CNT)
) chk (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.RUN_CMD_I(RUN_CMD_I), .JOG_I(JOG_I), .LINE_OK_I(LINE_OK_I),
	.FULL_SPEED_I(FULL_SPEED_I), .CURRENT_I(CURRENT_I),
	.EXT_TRIP_I(EXT_TRIP_I), .EXT_COND_I(EXT_COND_I),
	.MOTOR_ON_O(MOTOR_ON_O), .AT_SPEED_O(AT_SPEED_O), .TRIP_O(TRIP_O),
	.TRIP_CODE_O(TRIP_CODE_O)
);

// ===== tb/test_run_statistics_and_fault_tag.sv
// Testbench: directed scenarios for the run statistics and trip tag block
module test_run_statistics_and_fault_tag
	import run_stats_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TH = 20;
	localparam int PL = 10;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
	logic jog = 1'b0, line_ok = 1'b1, ext_trip = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, ext_cond = 16'h4F43, load = 16'h0100;
	logic [15:0] rdata, amps, v;
	logic motor_on, at_speed, trip, full_speed;
	logic [23:0] trip_code;
	int failures = 0;
	int checks_done = 0;
	int powered = 0;
	wire logic [2:0] st = {trip, at_speed, motor_on};
	run_statistics_and_fault_tag #(.TENTH_HOUR_CNT(TH), .PHASE_LOSS_CNT(PL))
	uut (
		.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.RUN_CMD_I(run), .JOG_I(jog), .LINE_OK_I(line_ok),
		.FULL_SPEED_I(full_speed), .CURRENT_I(amps), .EXT_TRIP_I(ext_trip),
		.EXT_COND_I(ext_cond), .MOTOR_ON_O(motor_on), .AT_SPEED_O(at_speed),
		.TRIP_O(trip), .TRIP_CODE_O(trip_code));
	motor_stage_model motor (.clk_i(clk), .rst_n_i(rst_n),
		.motor_on_i(motor_on), .load_i(load), .full_speed_o(full_speed),
		.current_o(amps));
	// ----
	// Clock, powered-time tally, watchdog
	// ----
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (motor_on === 1'b1)
			powered++;
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		close_out();
	end
	task automatic close_out();
		if (failures == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----
	// Bus and compare helpers
	// ----
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Bounded wait for one status output, then judged
	task automatic expect_st(input int k, input logic lvl, input int n);
		for (int i = 0; i < n && st[k] !== lvl; i++)
			@(negedge clk);
		chk(24'(st[k]), 24'(lvl));
	endtask
	task automatic set_run(input logic r);
		@(posedge clk);
		run <= r;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		reg_wr(ADDR_RUN_HOURS_BASIC, 16'h1234);
		for (int a = 0; a < 5; a++) begin
			reg_rd((a == 4) ? 4'hF : 4'(a), v);
			chk(24'(v), 24'h0);
		end
		reg_rd(ADDR_STATUS, v);
		chk(24'(v[4]), 24'h1);
	endtask
	task automatic t_refuse();
		set_run(1'b1);
		hold(8);
		chk(24'(motor_on), 24'h0);
		reg_wr(ADDR_FULL_LOAD_CURRENT, 16'h0064);
		line_ok <= 1'b0;
		hold(8);
		chk(24'(motor_on), 24'h0);
		@(posedge clk);
		run <= 1'b0;
		line_ok <= 1'b1;
		hold(8);
		chk(24'(motor_on), 24'h0);
	endtask
	task automatic t_start();
		set_run(1'b1);
		expect_st(0, 1'b1, 3);
		expect_st(1, 1'b1, 12);
		hold(2);
		reg_rd(ADDR_RUN_CYCLES_BASIC, v);
		chk(24'(v), 24'h1);
		set_run(1'b0);
		expect_st(1, 1'b0, 2);
		// A start dropped before full speed must not count
		set_run(1'b1);
		hold(3);
		set_run(1'b0);
		hold(3);
		reg_rd(ADDR_RUN_CYCLES_BASIC, v);
		chk(24'(v), 24'h1);
	endtask
	task automatic t_soft();
		reg_wr(ADDR_CONTROL, 16'h0003);
		reg_wr(ADDR_STOP_LEVEL, 16'h0040);
		run <= 1'b1;
		expect_st(1, 1'b1, 14);
		set_run(1'b0);
		hold(6);
		chk(24'(st[1:0]), 24'h1);
		@(posedge clk);
		load <= 16'h0040;
		expect_st(0, 1'b0, 3);
		@(posedge clk);
		load <= 16'h0100;
	endtask
	task automatic trip_at(input logic [7:0] ph);
		@(posedge clk);
		ext_trip <= 1'b1;
		@(posedge clk);
		ext_trip <= 1'b0;
		run <= 1'b0;
		hold(1);
		chk(trip_code, {ext_cond, ph});
		reg_wr(ADDR_CONTROL, 16'h0007);
		hold(1);
		chk(24'(trip), 24'h0);
		reg_rd(ADDR_TRIP_CODE, v);
		chk(24'(v), {16'h0000, ph});
	endtask
	task automatic t_trips();
		trip_at(CHAR_DECEL);
		set_run(1'b1);
		expect_st(0, 1'b1, 3);
		trip_at(CHAR_ACCEL);
		// Trip-clear bit must not stick in the control register
		reg_rd(ADDR_CONTROL, v);
		chk(24'(v), 24'h3);
		set_run(1'b1);
		expect_st(1, 1'b1, 14);
		trip_at(CHAR_CONST);
		set_run(1'b1);
		expect_st(1, 1'b1, 14);
		set_run(1'b0);
		hold(2);
		trip_at(CHAR_DECEL);
	endtask
	task automatic t_phase_loss();
		reg_wr(ADDR_LOW_CURRENT, 16'h0050);
		run <= 1'b1;
		expect_st(1, 1'b1, 14);
		@(posedge clk);
		load <= 16'h0004;
		hold(PL - 2);
		chk(24'(trip), 24'h0);
		expect_st(2, 1'b1, 6);
		chk(trip_code, {COND_PHASE_LOSS, CHAR_CONST});
		@(posedge clk);
		run <= 1'b0;
		load <= 16'h0100;
		reg_wr(ADDR_CONTROL, 16'h0006);
		hold(1);
		chk(24'(trip), 24'h0);
	endtask
	task automatic t_jog_hours();
		@(posedge clk);
		jog <= 1'b1;
		expect_st(0, 1'b1, 3);
		hold(120);
		@(posedge clk);
		jog <= 1'b0;
		expect_st(0, 1'b0, 3);
		reg_rd(ADDR_RUN_HOURS_BASIC, v);
		// One tick of slack for the count's own pipeline
		chk(24'(16'(powered / TH) - v <= 16'h0001), 24'h1);
		reg_rd(ADDR_RUN_HOURS_THOUSANDS, v);
		chk(24'(v), 24'h0);
		// Reset after the jog has ended must bring the statistics back to zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(ADDR_RUN_CYCLES_BASIC, v);
		chk(24'(v), 24'h0);
		reg_rd(ADDR_RUN_HOURS_BASIC, v);
		chk(24'(v), 24'h0);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_refuse();
		t_start();
		t_soft();
		t_trips();
		t_phase_loss();
		t_jog_hours();
		close_out();
	end
endmodule
